/* adc_ctrl_defines.svh */
// Constants for the converter channel, GPIO and timing control block
//
// Summary of operation
// - While software reset runs every channel works as an analog input; pin_func_i applies again after it.
// - Each channel's function select bit switches it from analog to GPIO.
// - A GPIO channel's direction bit selects input or output.
// - Digital input level reports the sampled level of digital input channels.
// - Digital output channels drive the level written in digital output level.
// - Output drive type bit picks open-drain or push-pull per channel.
// - Results are 12-bit unsigned straight binary codes, LSB equals reference over 4096.
// - Software reset completes within 5 ms, then its bit clears itself.
// - Conversions are timed internally; the host supplies no conversion clock.
// - Manual mode serves host requests; autonomous mode sequences channels alone.
// - Alert is raised when a monitored channel crosses its high or low threshold.
// - With averaging on, the result is a 16-bit filtered value.
// - A 16-bit true RMS value of one selected channel over a window.
// - Zero-cross output toggles as a selected channel crosses its threshold.
// - Digital input level also shows the real pin level of output channels.
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

// ==========================================================================
// Widths and reset values
`define NUM_CH          8
`define CODE_BITS       12
`define AVG_BITS        16
`define AVG_SAMPLES_L2  4
`define RMS_WIN_L2      6
`define PIN_CFG_RST     8'h00

// ==========================================================================
// Timing
`define CLK_MHZ         25
`define T_CYCLE_NS      1000
`define CYCLE_CLKS      ((`T_CYCLE_NS * `CLK_MHZ + 999) / 1000)
`define T_RST_MS        5
`define RST_CLKS        (`T_RST_MS * `CLK_MHZ * 1000)

`endif

/* adc_ctrl_pkg.sv */
// Types for the converter channel, GPIO and timing control block
`default_nettype none
package adc_ctrl_pkg;

	typedef enum logic [1:0] {ST_IDLE, ST_CONV} conv_st_t;

	typedef struct packed {
		conv_st_t    st;
		logic        soft_busy;
		logic [23:0] rst_cnt;
		logic [15:0] tick_cnt;
		logic [2:0]  chan;
		logic        conv_start;
		logic [3:0]  avg_cnt;
		logic [15:0] avg_acc;
		logic [15:0] result;
		logic [2:0]  result_chan;
		logic        result_valid;
		logic [7:0]  gpi;
		logic [7:0]  pin_out;
		logic [7:0]  pin_oe;
		logic [7:0]  alert;
		logic        zero_cross_detect;
		logic [7:0]  rms_cnt;
		logic [31:0] rms_acc;
		logic [31:0] rms_rad;
		logic        rms_start;
		logic [15:0] rms;
		logic        rms_valid;
	} ctrl_state_t;

	typedef struct packed {
		logic        busy;
		logic        done;
		logic [3:0]  idx;
		logic [31:0] rad;
		logic [15:0] root;
	} sqrt_state_t;

endpackage
`default_nettype wire

/* sqrt_if.sv */
// Request and answer between the control block and the square root unit
`timescale 1ns/10ps
`default_nettype none
interface sqrt_if;
	logic        start;
	logic [31:0] radicand;
	logic        done;
	logic [15:0] root;
	modport master (output start, output radicand, input done, input root);
	modport slave  (input start, input radicand, output done, output root);
endinterface
`default_nettype wire

/* int_sqrt.sv */
// Iterative integer square root, one result bit per clock
`timescale 1ns/10ps
`default_nettype none
module int_sqrt
	import adc_ctrl_pkg::*;
(
	input  wire logic sys_clk_i,
	input  wire logic nrst_i,
	sqrt_if.slave     sq
);
	sqrt_state_t s_r;
	sqrt_state_t s_nxt;
	logic [15:0] trial;

	// ==========================================================================
	// Next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		trial = s_r.root | (16'h0001 << s_r.idx);
		if (!s_r.busy) begin
			if (sq.start) begin
				s_nxt.busy = 1'b1;
				s_nxt.idx  = 4'hF;
				s_nxt.rad  = sq.radicand;
				s_nxt.root = 16'h0000;
			end
		end else begin
			if (32'(trial) * 32'(trial) <= s_r.rad) begin
				s_nxt.root = trial;
			end
			if (s_r.idx == 4'h0) begin
				s_nxt.busy = 1'b0;
				s_nxt.done = 1'b1;
			end else begin
				s_nxt.idx = s_r.idx - 4'h1;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sq.done = s_r.done;
	assign sq.root = s_r.root;

	// ==========================================================================
	// Checks
	AST_SQRT_LEN: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(sq.start && !s_r.busy) |-> ##17 sq.done)
		else $error("square root did not finish in 17 cycles");

endmodule
`default_nettype wire

/* adc_channel_mux_gpio_control.sv */
// Channel function, GPIO, conversion sequencing, averaging, alert, RMS and zero-cross control
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctrl_defines.svh"
module adc_channel_mux_gpio_control
	import adc_ctrl_pkg::*;
#(
	parameter int NUM_CH     = `NUM_CH,
	parameter int CYCLE_CLKS = `CYCLE_CLKS,
	parameter int RST_CLKS   = `RST_CLKS,
	parameter int RMS_WIN_L2 = `RMS_WIN_L2
) (
	input  wire logic              sys_clk_i,
	input  wire logic              nrst_i,
	input  wire logic              soft_rst_req_i,
	output logic                   soft_rst_busy_o,
	input  wire logic [7:0]        pin_func_i,
	input  wire logic [7:0]        gpio_dir_i,
	input  wire logic [7:0]        output_drive_type_i,
	input  wire logic [7:0]        digital_output_level_i,
	output logic [7:0]             digital_input_level_o,
	input  wire logic [7:0]        chan_in_i,
	output logic [7:0]             chan_out_o,
	output logic [7:0]             chan_oe_o,
	input  wire logic              auto_en_i,
	input  wire logic              manual_req_i,
	input  wire logic [2:0]        manual_chan_i,
	output logic                   manual_ready_o,
	input  wire logic              avg_en_i,
	output logic                   conv_start_o,
	output logic [2:0]             conv_chan_o,
	input  wire logic              code_valid_i,
	input  wire logic [11:0]       code_i,
	output logic [15:0]            result_o,
	output logic [2:0]             result_chan_o,
	output logic                   result_valid_o,
	input  wire logic [7:0]        monitor_en_i,
	input  wire logic [7:0][11:0]  thr_hi_i,
	input  wire logic [7:0][11:0]  thr_lo_i,
	input  wire logic [7:0]        alert_clr_i,
	output logic                   alert_o,
	output logic [7:0]             alert_flags_o,
	input  wire logic              rms_en_i,
	input  wire logic [2:0]        rms_chan_i,
	output logic [15:0]            rms_o,
	output logic                   rms_valid_o,
	input  wire logic              zero_cross_detect_en_i,
	input  wire logic [2:0]        zero_cross_detect_chan_i,
	input  wire logic [11:0]       zero_cross_detect_thr_i,
	output logic                   zero_cross_detect_o
);

	// ==========================================================================
	// Parameter checks
	if (NUM_CH != 8) begin : g_chk_ch
		$error("NUM_CH must be 8");
	end
	if (CYCLE_CLKS < 1 || CYCLE_CLKS > 65535) begin : g_chk_cyc
		$error("CYCLE_CLKS out of range");
	end
	if (RST_CLKS < 1 || RST_CLKS > 16777215) begin : g_chk_rst
		$error("RST_CLKS out of range");
	end
	if (RMS_WIN_L2 < 1 || RMS_WIN_L2 > 8) begin : g_chk_rms
		$error("RMS_WIN_L2 must be 1 to 8");
	end

	// ==========================================================================
	// Helpers
	function automatic logic [2:0] next_chan(input logic [2:0] cur, input logic [7:0] mask);
		logic [2:0] c;
		logic       hit;
		c   = cur;
		hit = 1'b0;
		for (int k = 1; k <= 8; k++) begin
			if (!hit && mask[3'(cur + 3'(k))]) begin
				c   = 3'(cur + 3'(k));
				hit = 1'b1;
			end
		end
		return c;
	endfunction

	ctrl_state_t s_r;
	ctrl_state_t s_nxt;
	logic [7:0]  func;
	logic [7:0]  analog;
	logic        tick;
	sqrt_if      sq ();

	int_sqrt u_sqrt (
		.sys_clk_i (sys_clk_i),
		.nrst_i    (nrst_i),
		.sq        (sq.slave)
	);

	assign func   = s_r.soft_busy ? `PIN_CFG_RST : pin_func_i;
	assign analog = ~func;
	assign tick   = (s_r.tick_cnt == 16'h0000);

	// ==========================================================================
	// Next state
	always_comb begin
		logic [15:0] sum;
		logic [11:0] cmp;
		logic [23:0] sqr;
		logic [31:0] acc;
		logic        publish;
		sum     = 16'h0000;
		cmp     = 12'h000;
		sqr     = 24'h000000;
		acc     = 32'h00000000;
		publish = 1'b0;
		s_nxt   = s_r;
		s_nxt.conv_start   = 1'b0;
		s_nxt.result_valid = 1'b0;
		s_nxt.rms_valid    = 1'b0;
		s_nxt.rms_start    = 1'b0;
		s_nxt.tick_cnt = tick ? 16'(CYCLE_CLKS - 1) : s_r.tick_cnt - 16'h0001;
		s_nxt.gpi      = chan_in_i & func;
		for (int i = 0; i < 8; i++) begin
			s_nxt.pin_oe[i]  = func[i] & gpio_dir_i[i]
				& (output_drive_type_i[i] | ~digital_output_level_i[i]);
			s_nxt.pin_out[i] = func[i] & gpio_dir_i[i] & output_drive_type_i[i]
				& digital_output_level_i[i];
		end
		s_nxt.alert = s_r.alert & ~alert_clr_i;
		if (sq.done) begin
			s_nxt.rms       = sq.root;
			s_nxt.rms_valid = 1'b1;
		end
		case (s_r.st)
			ST_IDLE: begin
				if (s_r.avg_cnt != 4'h0) begin
					if (tick) begin
						s_nxt.st         = ST_CONV;
						s_nxt.conv_start = 1'b1;
					end
				end else if (auto_en_i) begin
					if (tick && (|analog)) begin
						s_nxt.chan       = next_chan(s_r.chan, analog);
						s_nxt.st         = ST_CONV;
						s_nxt.conv_start = 1'b1;
					end
				end else if (manual_req_i && analog[manual_chan_i]) begin
					s_nxt.chan       = manual_chan_i;
					s_nxt.st         = ST_CONV;
					s_nxt.conv_start = 1'b1;
				end
			end
			ST_CONV: begin
				if (code_valid_i) begin
					s_nxt.st = ST_IDLE;
					if (avg_en_i || s_r.avg_cnt != 4'h0) begin
						sum           = s_r.avg_acc + {4'h0, code_i};
						s_nxt.avg_cnt = s_r.avg_cnt + 4'h1;
						s_nxt.avg_acc = sum;
						if (s_r.avg_cnt == 4'hF) begin
							s_nxt.avg_acc = 16'h0000;
							s_nxt.result  = sum;
							cmp           = sum[15:4];
							publish       = 1'b1;
						end
					end else begin
						s_nxt.result = {4'h0, code_i};
						cmp          = code_i;
						publish      = 1'b1;
					end
					if (publish) begin
						s_nxt.result_chan  = s_r.chan;
						s_nxt.result_valid = 1'b1;
						if (monitor_en_i[s_r.chan]
							&& (cmp > thr_hi_i[s_r.chan] || cmp < thr_lo_i[s_r.chan])) begin
							s_nxt.alert[s_r.chan] = 1'b1;
						end
						if (zero_cross_detect_en_i && s_r.chan == zero_cross_detect_chan_i) begin
							s_nxt.zero_cross_detect = (cmp > zero_cross_detect_thr_i);
						end
					end
					if (rms_en_i && s_r.chan == rms_chan_i) begin
						sqr           = 24'(code_i) * 24'(code_i);
						acc           = s_r.rms_acc + {8'h00, sqr};
						s_nxt.rms_acc = acc;
						s_nxt.rms_cnt = s_r.rms_cnt + 8'h01;
						if (s_r.rms_cnt == 8'((1 << RMS_WIN_L2) - 1)) begin
							s_nxt.rms_rad   = {24'(acc >> RMS_WIN_L2), 8'h00};
							s_nxt.rms_start = 1'b1;
							s_nxt.rms_acc   = 32'h00000000;
							s_nxt.rms_cnt   = 8'h00;
						end
					end
				end
			end
			default: begin
				s_nxt.st = ST_IDLE;
			end
		endcase
		if (s_r.soft_busy) begin
			s_nxt           = '0;
			s_nxt.soft_busy = (s_r.rst_cnt != 24'h000000);
			s_nxt.rst_cnt   = s_r.rst_cnt - 24'h000001;
		end else if (soft_rst_req_i) begin
			s_nxt.soft_busy = 1'b1;
			s_nxt.rst_cnt   = 24'(RST_CLKS - 1);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================================
	// Outputs
	assign sq.start              = s_r.rms_start;
	assign sq.radicand           = s_r.rms_rad;
	assign soft_rst_busy_o       = s_r.soft_busy;
	assign digital_input_level_o = s_r.gpi;
	assign chan_out_o            = s_r.pin_out;
	assign chan_oe_o             = s_r.pin_oe;
	assign manual_ready_o        = (s_r.st == ST_IDLE) && !auto_en_i && !s_r.soft_busy
		&& (s_r.avg_cnt == 4'h0);
	assign conv_start_o          = s_r.conv_start;
	assign conv_chan_o           = s_r.chan;
	assign result_o              = s_r.result;
	assign result_chan_o         = s_r.result_chan;
	assign result_valid_o        = s_r.result_valid;
	assign alert_flags_o         = s_r.alert;
	assign alert_o               = |s_r.alert;
	assign rms_o                 = s_r.rms;
	assign rms_valid_o           = s_r.rms_valid;
	assign zero_cross_detect_o   = s_r.zero_cross_detect;

	// ==========================================================================
	// Checks
	logic [24:0] busy_len;
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i || !s_r.soft_busy) begin
			busy_len <= 25'h0000000;
		end else begin
			busy_len <= busy_len + 25'h0000001;
		end
	end

	AST_RST_BOUND: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		busy_len <= 25'(RST_CLKS))
		else $error("software reset held too long");
	AST_RST_ANALOG: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		s_r.soft_busy |=> (chan_oe_o == 8'h00 && digital_input_level_o == 8'h00))
		else $error("channel not analog during reset");
	AST_NO_DRIVE: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		!s_r.soft_busy |=> ((chan_oe_o & ~$past(pin_func_i)) == 8'h00))
		else $error("analog channel driven");
	AST_INPUT_DIR: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		!s_r.soft_busy |=> ((chan_oe_o & ~$past(gpio_dir_i)) == 8'h00))
		else $error("input channel driven");
	AST_GPI: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		!s_r.soft_busy |=> (digital_input_level_o == $past(chan_in_i & pin_func_i)))
		else $error("digital input level wrong");
	AST_PUSH_PULL: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		!s_r.soft_busy |=> ((chan_out_o ^ $past(digital_output_level_i))
			& $past(pin_func_i & gpio_dir_i & output_drive_type_i)) == 8'h00)
		else $error("push-pull level wrong");
	AST_OPEN_DRAIN: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		!s_r.soft_busy |=> ((chan_out_o | (chan_oe_o ^ ~$past(digital_output_level_i)))
			& $past(pin_func_i & gpio_dir_i & ~output_drive_type_i)) == 8'h00)
		else $error("open-drain drive wrong");
	AST_TICK: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		s_r.tick_cnt <= 16'(CYCLE_CLKS - 1))
		else $error("conversion timer out of range");
	AST_ALERT: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(s_r.st == ST_CONV && code_valid_i && !avg_en_i && s_r.avg_cnt == 4'h0 && !s_r.soft_busy
			&& !soft_rst_req_i && monitor_en_i[s_r.chan] && code_i > thr_hi_i[s_r.chan])
			|=> alert_o)
		else $error("alert not raised");
	AST_RAW_CODE: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(s_r.st == ST_CONV && code_valid_i && !avg_en_i && s_r.avg_cnt == 4'h0 && !s_r.soft_busy
			&& !soft_rst_req_i) |=> (result_valid_o && result_o == {4'h0, $past(code_i)}))
		else $error("raw result wrong");

endmodule
`default_nettype wire

/* adc_core_model.sv */
// Analog core model: answers each conversion start with a table code
`timescale 1ns/10ps
`default_nettype none
module adc_core_model #(
	parameter int LAT = 4
) (
	input  wire logic             clk_i,
	input  wire logic             start_i,
	input  wire logic [2:0]       chan_i,
	input  wire logic [7:0][11:0] codes_i,
	output logic                  valid_o,
	output logic [11:0]           code_o
);
	// ==========
	// Conversion latency and code output
	int          cnt = 0;
	logic [2:0]  ch = 3'h0;
	logic [11:0] last = 12'h000;
	initial valid_o = 1'b0;
	initial code_o = 12'h000;
	always @(posedge clk_i) begin
		valid_o <= 1'b0;
		code_o  <= ~last;
		if (start_i) begin
			cnt <= LAT;
			ch  <= chan_i;
		end else if (cnt == 1) begin
			valid_o <= 1'b1;
			code_o  <= codes_i[ch];
			last    <= codes_i[ch];
			cnt     <= 0;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end
	end
endmodule
`default_nettype wire

/* test_adc_channel_mux_gpio_control.sv */
// Self-checking bench for the channel, GPIO and conversion control block
`timescale 1ns/10ps
`default_nettype none
module test_adc_channel_mux_gpio_control;
	localparam int CYC = 10;
	localparam int RSTC = 20;
	logic             clk, nrst, srq, busy, avg, aut, mreq, mrdy, cst, cv, rv, alert;
	logic             rms_en, rmsv, zen, zero_cross_detect;
	logic [2:0]       mch, cch, rch, rms_ch, zch;
	logic [7:0]       func, dir, drv, lvl, ext, pin, dil, cout, coe, mon, aclr, afl;
	logic [7:0][11:0] hi, lo, codes;
	logic [11:0]      code, zthr;
	logic [15:0]      res, rms;
	int               n_mismatch = 0;
	int               compares = 0;
	int               k;

	// ==========
	// Pin resolution: driven level or external pull
	assign pin = (coe & cout) | (~coe & ext);

	adc_channel_mux_gpio_control #(.CYCLE_CLKS(CYC), .RST_CLKS(RSTC), .RMS_WIN_L2(1)) dut (
		.sys_clk_i(clk), .nrst_i(nrst), .soft_rst_req_i(srq), .soft_rst_busy_o(busy),
		.pin_func_i(func), .gpio_dir_i(dir), .output_drive_type_i(drv), .digital_output_level_i(lvl),
		.digital_input_level_o(dil), .chan_in_i(pin), .chan_out_o(cout), .chan_oe_o(coe),
		.auto_en_i(aut), .manual_req_i(mreq), .manual_chan_i(mch), .manual_ready_o(mrdy),
		.avg_en_i(avg), .conv_start_o(cst), .conv_chan_o(cch), .code_valid_i(cv), .code_i(code),
		.result_o(res), .result_chan_o(rch), .result_valid_o(rv), .monitor_en_i(mon),
		.thr_hi_i(hi), .thr_lo_i(lo), .alert_clr_i(aclr), .alert_o(alert), .alert_flags_o(afl),
		.rms_en_i(rms_en), .rms_chan_i(rms_ch), .rms_o(rms), .rms_valid_o(rmsv),
		.zero_cross_detect_en_i(zen), .zero_cross_detect_chan_i(zch),
		.zero_cross_detect_thr_i(zthr), .zero_cross_detect_o(zero_cross_detect)
	);

	adc_core_model #(.LAT(4)) core (
		.clk_i(clk), .start_i(cst), .chan_i(cch), .codes_i(codes), .valid_o(cv), .code_o(code)
	);

	// ==========
	// Compare and closing tasks
	task automatic cmp_vec(input logic [15:0] got, input logic [15:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp, input string what);
		cmp_vec({15'h0000, got}, {15'h0000, exp}, what);
	endtask

	task automatic tally_and_finish;
		if (n_mismatch == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ==========
	// Manual conversion request, held until manual ready is seen (at most 8 cycles)
	task automatic conv(input logic [2:0] ch, input logic ok, input logic [15:0] exp);
		@(posedge clk);
		mreq <= 1'b1;
		mch  <= ch;
		for (k = 0; k < 8; k++) begin
			@(negedge clk);
			if (mrdy === 1'b1) break;
		end
		@(posedge clk);
		mreq <= 1'b0;
		@(negedge clk);
		cmp_bit(cst, ok, "start");
		if (ok) begin
			cmp_vec({13'h0000, cch}, {13'h0000, ch}, "start chan");
			for (k = 0; k < 400 && rv !== 1'b1; k++) @(negedge clk);
			cmp_bit(rv, 1'b1, "result valid");
			cmp_vec(res, exp, "result");
			cmp_vec({13'h0000, rch}, {13'h0000, ch}, "result chan");
		end
	endtask

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		#400000;
		n_mismatch++;
		tally_and_finish;
	end

	initial begin
		nrst = 1'b0;
		srq = 1'b0;
		func = 8'h00;
		dir = 8'h00;
		drv = 8'h00;
		lvl = 8'h00;
		ext = 8'h00;
		aut = 1'b0;
		mreq = 1'b0;
		mch = 3'h0;
		avg = 1'b0;
		mon = 8'h24;
		aclr = 8'h00;
		rms_en = 1'b1;
		rms_ch = 3'h1;
		zen = 1'b1;
		zch = 3'h3;
		zthr = 12'h000;
		for (int i = 0; i < 8; i++) begin
			codes[i] = {3'(i), 9'h0A5};
			hi[i] = 12'hFFF;
			lo[i] = 12'h000;
		end
		hi[2] = 12'h000;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		cmp_vec({8'h00, coe}, 16'h0000, "oe after reset");
		cmp_vec({8'h00, dil}, 16'h0000, "gpi after reset");
		cmp_bit(busy, 1'b0, "busy after reset");
		// ==========
		// Mixed channel setup: analog, inputs, open-drain, push-pull
		@(posedge clk);
		func <= 8'hFE;
		dir <= 8'hF9;
		drv <= 8'hC1;
		lvl <= 8'h71;
		ext <= 8'h92;
		repeat (3) @(negedge clk);
		cmp_vec({8'h00, coe}, 16'h00C8, "oe");
		cmp_vec({8'h00, cout}, 16'h0040, "out");
		cmp_vec({8'h00, dil}, 16'h0052, "gpi");
		// ==========
		// Software reset
		@(posedge clk);
		srq <= 1'b1;
		@(posedge clk);
		srq <= 1'b0;
		@(negedge clk);
		cmp_bit(busy, 1'b1, "busy in soft reset");
		cmp_bit(mrdy, 1'b0, "ready in soft reset");
		@(negedge clk);
		cmp_vec({8'h00, coe}, 16'h0000, "oe in soft reset");
		for (k = 0; busy === 1'b1 && k < 100; k++) @(negedge clk);
		cmp_vec(16'(k + 1), 16'(RSTC), "soft reset length");
		repeat (2) @(negedge clk);
		cmp_vec({8'h00, coe}, 16'h00C8, "oe after soft reset");
		@(posedge clk);
		func <= 8'h10;
		// ==========
		// Conversions, refusal, alert, zero cross
		conv(3'h3, 1'b1, {4'h0, codes[3]});
		@(negedge clk);
		cmp_bit(zero_cross_detect, 1'b1, "zcd above");
		conv(3'h4, 1'b0, 16'h0000);
		conv(3'h5, 1'b1, {4'h0, codes[5]});
		@(negedge clk);
		cmp_bit(alert, 1'b0, "alert in range");
		conv(3'h2, 1'b1, {4'h0, codes[2]});
		@(negedge clk);
		cmp_vec({8'h00, afl}, 16'h0004, "alert flags");
		cmp_bit(alert, 1'b1, "alert");
		@(posedge clk);
		aclr <= 8'h04;
		zthr <= 12'hFFF;
		@(posedge clk);
		aclr <= 8'h00;
		repeat (2) @(negedge clk);
		cmp_bit(alert, 1'b0, "alert cleared");
		conv(3'h3, 1'b1, {4'h0, codes[3]});
		@(negedge clk);
		cmp_bit(zero_cross_detect, 1'b0, "zcd below");
		// ==========
		// RMS over two samples, then averaging
		conv(3'h1, 1'b1, {4'h0, codes[1]});
		conv(3'h1, 1'b1, {4'h0, codes[1]});
		for (k = 0; k < 60 && rmsv !== 1'b1; k++) @(negedge clk);
		cmp_bit(rmsv, 1'b1, "rms valid");
		cmp_vec(rms, {codes[1], 4'h0}, "rms");
		@(posedge clk);
		avg <= 1'b1;
		conv(3'h6, 1'b1, {codes[6], 4'h0});
		@(posedge clk);
		avg <= 1'b0;
		aut <= 1'b1;
		@(negedge clk);
		// ==========
		// Autonomous sequencing without host requests
		for (k = 0; k < 100 && rv !== 1'b1; k++) @(negedge clk);
		cmp_bit(rv, 1'b1, "auto result");
		cmp_vec(res, {4'h0, codes[7]}, "auto code");
		cmp_vec({13'h0000, rch}, 16'h0007, "auto chan");
		cmp_bit(func[rch], 1'b0, "auto on analog");
		@(posedge clk);
		aut <= 1'b0;
		repeat (20) @(negedge clk);
		tally_and_finish;
	end
endmodule
`default_nettype wire
